// ---- ptfc_checker.sv ----
// pasid-table entry fault checker: classifies one request per strobe
// assumes entry, request and capability inputs are stable with req_valid
`timescale 1ns/1ps

// timing: verdict registered one edge after the request strobe
// rsp_valid stands one cycle; result, reason and fault hold until the
// next request, so a slow consumer may still read them late
// translated requests pass untouched; their checks ran at translation time
// width and paging-mode support come in as masks from the integrator,
// so one netlist serves any capability set
// priority, highest first: not present, reserved bits, width or type,
// paging mode, execute, supervisor
// verdict codes on rsp_result, one-hot: pass, unsupported request,
// completer abort, zero-permission success, invalid request, drop
// limitation: context, directory and paging-entry faults are not seen
// here, nor is fault recording; the caller merges those verdicts
// inputs must settle within one cycle; the whole check is combinational
// between the entry inputs and the verdict register

// Overview of operation
// - entry not present: reason 59h; UR, zero-permission success, IR or drop.
// - present entry with reserved bits set: reason 5Ah; UR, CA, IR or drop.
// - unsupported address width: reason 5Bh; UR, CA, IR or drop.
// - type codes 000b, 101b, 110b, 111b always unsupported: reason 5Bh.
// - type 001b needs first-stage cap; 010b needs second-stage cap.
// - type 011b needs nested cap; 100b needs pass-through cap.
// - unsupported first-stage paging mode: 5Bh, UR or CA; page requests exempt.
// - execute asked with pasid, execute disabled: 5Ch, UR or zero-permission success.
// - privileged access, supervisor disabled: 5Dh, UR or zero-permission success.
// - privilege may come from context default privilege instead of the request.
module ptfc_checker (
    input  wire logic                  sys_clk,      // 250 MHz clock
    input  wire logic                  rst_n,        // async reset, active low
    input  wire logic                  req_valid,    // one-cycle request strobe
    input  wire ptfc_pkg::ptfc_req_s   req,          // request attributes
    input  wire ptfc_pkg::ptfc_entry_s entry,        // fetched table entry
    input  wire ptfc_pkg::ptfc_cap_s   cap,          // capability bits
    input  wire logic                  use_ctx_priv, // take privilege from context
    input  wire logic                  ctx_default_privilege, // context privilege
    output logic                       rsp_valid,    // verdict strobe
    output ptfc_pkg::ptfc_res_e        rsp_result,   // outcome
    output logic [7:0]                 rsp_reason,   // fault reason code
    output logic                       rsp_fault     // a fault was found
);

    // all state in one word; the checks are pure decode, only the verdict
    // is remembered, so there is nothing to flush between requests
    typedef struct packed {
        ptfc_pkg::ptfc_out_s o;
    } ptfc_state_s;

    ptfc_state_s state_q;
    ptfc_state_s state_d;
    logic        tt_bad;

    // type support decode lives in its own module
    ptfc_tt_check u_tt (
        .tt  (entry.translation_type_field),
        .cap (cap),
        .bad (tt_bad)
    );

    // outcome of a fault row: zperm picks zero-permission success over
    // completer abort for translation requests; page requests take the
    // response column; translated requests never reach a fault row
    function automatic ptfc_pkg::ptfc_res_e map_res(
        input ptfc_pkg::ptfc_req_e kind,
        input logic                zperm,
        input logic                need_rsp
    );
        case (kind)
            ptfc_pkg::PTFC_REQ_UNTRANS: begin
                map_res = ptfc_pkg::PTFC_RES_UR;
            end
            ptfc_pkg::PTFC_REQ_XLATE: begin
                if (zperm) begin
                    map_res = ptfc_pkg::PTFC_RES_ZPERM;
                end else begin
                    map_res = ptfc_pkg::PTFC_RES_CA;
                end
            end
            ptfc_pkg::PTFC_REQ_PAGE: begin
                if (need_rsp) begin
                    map_res = ptfc_pkg::PTFC_RES_IR;
                end else begin
                    map_res = ptfc_pkg::PTFC_RES_DROP;
                end
            end
            default: begin
                map_res = ptfc_pkg::PTFC_RES_PASS;
            end
        endcase
    endfunction

    // one verdict word; fault derived from the reason so they never disagree
    function automatic ptfc_pkg::ptfc_out_s make_verdict(
        input logic [7:0]          reason,
        input ptfc_pkg::ptfc_res_e result
    );
        ptfc_pkg::ptfc_out_s v;
        v.valid      = 1'b1;
        v.result     = result;
        v.reason     = reason;
        v.fault      = (reason != ptfc_pkg::FR_NONE);
        make_verdict = v;
    endfunction

    // raw condition flags, before the priority chain ranks them
    // each flag ignores the others; rank is decided only in the chain
    logic                priv;      // privileged access asked
    logic                is_page;   // page request
    logic                is_xlated; // translated request
    logic                width_bad; // address width not supported
    logic                mode_bad;  // paging mode not supported
    logic                exec_bad;  // execute asked, not enabled
    logic                supv_bad;  // privileged access, not enabled
    ptfc_pkg::ptfc_res_e res_zperm; // outcome, zero-permission column
    ptfc_pkg::ptfc_res_e res_ca;    // outcome, completer-abort column
    ptfc_pkg::ptfc_res_e res_perm;  // outcome, permission rows

    // request class from the one-hot kind
    always_comb begin
        is_page   = (req.kind == ptfc_pkg::PTFC_REQ_PAGE);
        is_xlated = (req.kind == ptfc_pkg::PTFC_REQ_XLATED);
    end

    // privilege source select
    // context default replaces the request privilege bit whenever use_ctx_priv is set
    always_comb begin
        priv = use_ctx_priv ? ctx_default_privilege : req.supervisor_access_flag;
    end

    // address width and paging mode support
    // page requests are exempt from the paging mode row
    always_comb begin
        width_bad = !cap.addr_width_supported[entry.addr_width_field];
        mode_bad  = !is_page && !cap.paging_mode_supported[entry.first_stage_paging_mode];
    end

    // execute and supervisor permission
    // both rows are empty for page requests, so those skip them
    always_comb begin
        exec_bad = !is_page && req.with_pasid && req.execute_flag &&
                   !entry.exec_req_enable;
        supv_bad = !is_page && priv && !entry.supervisor_req_enable;
    end

    // outcome per column; the permission rows never answer a page request,
    // so their response flag is tied low
    always_comb begin
        res_zperm = map_res(req.kind, 1'b1, req.needs_response);
        res_ca    = map_res(req.kind, 1'b0, req.needs_response);
        res_perm  = map_res(req.kind, 1'b1, 1'b0);
    end

    // fault priority chain; first match wins, so one reason per request
    // the register keeps the last verdict while no request is offered
    always_comb begin
        state_d         = state_q;
        state_d.o.valid = req_valid;
        if (req_valid) begin
            // present first, one reason
            // translated requests were checked when they were translated
            if (is_xlated) begin
                state_d.o = make_verdict(ptfc_pkg::FR_NONE, ptfc_pkg::PTFC_RES_PASS);
            end else if (!entry.present) begin
                // not present
                // untranslated UR, translation zero-perm, page IR or drop
                state_d.o = make_verdict(ptfc_pkg::FR_NOT_PRES, res_zperm);
            end else if (entry.rsvd_nonzero) begin
                // reserved bits
                // untranslated UR, translation CA, page IR or drop
                state_d.o = make_verdict(ptfc_pkg::FR_RSVD, res_ca);
            end else if (width_bad || tt_bad) begin
                // address width, type code
                // same columns as reserved bits
                state_d.o = make_verdict(ptfc_pkg::FR_BAD_PROG, res_ca);
            end else if (mode_bad) begin
                state_d.o = make_verdict(ptfc_pkg::FR_BAD_PROG, res_ca);
            end else if (exec_bad) begin
                // execute not enabled
                // untranslated UR, translation zero-perm
                state_d.o = make_verdict(ptfc_pkg::FR_NO_EXEC, res_perm);
            end else if (supv_bad) begin
                state_d.o = make_verdict(ptfc_pkg::FR_NO_SUPV, res_perm);
            end else begin
                // clean entry; request goes on to the walk
                state_d.o = make_verdict(ptfc_pkg::FR_NONE, ptfc_pkg::PTFC_RES_PASS);
            end
        end
    end

    // single state register; verdict holds until next request
    // reset branch loads constants only
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q.o.valid  <= 1'b0;
            state_q.o.result <= ptfc_pkg::PTFC_RES_PASS;
            state_q.o.reason <= ptfc_pkg::RST_REASON;
            state_q.o.fault  <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    // outputs straight from the state register, no logic after the flops
    assign rsp_valid  = state_q.o.valid;
    assign rsp_result = state_q.o.result;
    assign rsp_reason = state_q.o.reason;
    assign rsp_fault  = state_q.o.fault;

endmodule // ptfc_checker

// ---- ptfc_pkg.sv ----
// package for the pasid-table entry fault checker: codes, encodings, carriers
// assumes a single 250 MHz clock domain; no registers are bus-mapped
package ptfc_pkg;

    // fault reason codes
    localparam logic [7:0] FR_NONE       = 8'h00;
    localparam logic [7:0] FR_NOT_PRES   = 8'h59;
    localparam logic [7:0] FR_RSVD       = 8'h5A;
    localparam logic [7:0] FR_BAD_PROG   = 8'h5B;
    localparam logic [7:0] FR_NO_EXEC    = 8'h5C;
    localparam logic [7:0] FR_NO_SUPV    = 8'h5D;

    // translation_type_field encodings
    localparam logic [2:0] TT_RSVD0      = 3'h0;
    localparam logic [2:0] TT_FIRST      = 3'h1;
    localparam logic [2:0] TT_SECOND     = 3'h2;
    localparam logic [2:0] TT_NESTED     = 3'h3;
    localparam logic [2:0] TT_PASSTHRU   = 3'h4;

    // reset values
    localparam logic [7:0] RST_REASON    = 8'h00;

    // request kinds
    typedef enum logic [3:0] {
        PTFC_REQ_UNTRANS = 4'h1,
        PTFC_REQ_XLATE   = 4'h2,
        PTFC_REQ_XLATED  = 4'h4,
        PTFC_REQ_PAGE    = 4'h8
    } ptfc_req_e;

    // outcome of the check, one-hot
    typedef enum logic [5:0] {
        PTFC_RES_PASS    = 6'h01,
        PTFC_RES_UR      = 6'h02,
        PTFC_RES_CA      = 6'h04,
        PTFC_RES_ZPERM   = 6'h08,
        PTFC_RES_IR      = 6'h10,
        PTFC_RES_DROP    = 6'h20
    } ptfc_res_e;

    // request attributes
    typedef struct packed {
        ptfc_req_e  kind;
        logic       with_pasid;
        logic       execute_flag;
        logic       supervisor_access_flag;
        logic       needs_response;
    } ptfc_req_s;

    // fields of the fetched pasid-table entry that are checked
    typedef struct packed {
        logic       present;
        logic       rsvd_nonzero;
        logic [2:0] addr_width_field;
        logic [2:0] translation_type_field;
        logic [1:0] first_stage_paging_mode;
        logic       exec_req_enable;
        logic       supervisor_req_enable;
    } ptfc_entry_s;

    // capability bits of the extended_capability_reg and supported masks
    typedef struct packed {
        logic       first_stage_support_cap;
        logic       second_stage_support_cap;
        logic       two_level_support_cap;
        logic       passthrough_support_cap;
        logic [7:0] addr_width_supported;  // one bit per addr_width_field value
        logic [3:0] paging_mode_supported; // one bit per paging mode value
    } ptfc_cap_s;

    // registered verdict
    typedef struct packed {
        logic       valid;
        ptfc_res_e  result;
        logic [7:0] reason;
        logic       fault;
    } ptfc_out_s;

endpackage

// ---- ptfc_tt_check.sv ----
// translation-type support decode for the pasid-table entry checker
// purely combinational; caller registers the answer
`timescale 1ns/1ps

module ptfc_tt_check (
    input  wire logic [2:0]          tt,  // translation_type_field
    input  wire ptfc_pkg::ptfc_cap_s cap, // capability bits
    output logic                     bad  // unsupported type
);

    // capability gating per type; 000b and 101b..111b never legal
    always_comb begin
        case (tt)
            ptfc_pkg::TT_FIRST:    bad = !cap.first_stage_support_cap;
            ptfc_pkg::TT_SECOND:   bad = !cap.second_stage_support_cap;
            ptfc_pkg::TT_NESTED:   bad = !cap.two_level_support_cap;
            ptfc_pkg::TT_PASSTHRU: bad = !cap.passthrough_support_cap;
            default:               bad = 1'b1;
        endcase
    end

endmodule // ptfc_tt_check

// ---- ptfc_checker_assertions.sv ----
// assertions on the fault checker verdict ports
// bound to ptfc_checker; one clock, async low reset
`timescale 1ns/1ps
module ptfc_checker_assertions (
    input wire logic                  sys_clk,    // clock
    input wire logic                  rst_n,      // reset
    input wire logic                  req_valid,  // strobe
    input wire ptfc_pkg::ptfc_req_s   req,        // request
    input wire ptfc_pkg::ptfc_entry_s entry,      // entry
    input wire logic                  rsp_valid,  // verdict
    input wire ptfc_pkg::ptfc_res_e   rsp_result, // outcome
    input wire logic [7:0]            rsp_reason, // reason
    input wire logic                  rsp_fault   // fault
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // translated requests bypass every entry check
    wire       fwd = req_valid && req.kind != ptfc_pkg::PTFC_REQ_XLATED;
    wire       pr  = fwd && entry.present;
    wire [2:0] tt  = entry.translation_type_field;
    rsp_latency_a: assert property (req_valid |=> rsp_valid)
        else $error("late verdict");
    verdict_hold_a: assert property (!req_valid |=> !rsp_valid && $stable(rsp_reason))
        else $error("verdict moved");
    absent_reason_a: assert property (fwd && !entry.present |=> rsp_reason == 8'h59)
        else $error("absent reason");
    absent_untrans_a: assert property (fwd && !entry.present && req.kind == 4'h1
        |=> rsp_result == 6'h02) else $error("absent result");
    reserved_reason_a: assert property (pr && entry.rsvd_nonzero |=> rsp_reason == 8'h5A)
        else $error("reserved reason");
    bad_type_a: assert property (pr && !entry.rsvd_nonzero && (tt == 3'h0 || tt > 3'h4)
        |=> rsp_reason == 8'h5B) else $error("type reason");
    xlated_pass_a: assert property (req_valid && !fwd
        |=> rsp_reason == 8'h00 && rsp_result == 6'h01) else $error("translated");
    fault_flag_a: assert property (rsp_valid |-> rsp_fault == (rsp_reason != 8'h00))
        else $error("fault flag");
endmodule // ptfc_checker_assertions
bind ptfc_checker ptfc_checker_assertions u_sva (.*);

// ---- ptfc_ep_model.sv ----
// endpoint request source: one request per go pulse
// bench holds cmd with go for one cycle
`timescale 1ns/1ps
module ptfc_ep_model (
    input  wire logic                sys_clk,   // clock
    input  wire logic                rst_n,     // reset
    input  wire logic                go,        // launch
    input  wire ptfc_pkg::ptfc_req_s cmd,       // request
    output logic                     req_valid, // strobe
    output ptfc_pkg::ptfc_req_s      req        // attributes
);
    // scrambled between requests so a stale sample shows up
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) {req_valid, req} <= '0;
        else {req_valid, req} <= go ? {1'b1, cmd} : {1'b0, ~req};
    end
endmodule // ptfc_ep_model

// ---- ptfc_checker_tb.sv ----
// self-checking bench for the pasid-table entry fault checker
// requests go through the endpoint model; one 250 MHz clock
`timescale 1ns/1ps
module ptfc_checker_tb;
    logic sys_clk = 1'b0, rst_n = 1'b0, go = 1'b0, bad;
    logic use_ctx_priv = 1'b0, ctx_default_privilege = 1'b0;
    logic req_valid, rsp_valid, rsp_fault;
    logic [7:0] rsp_reason;
    int failures = 0, n_checks = 0;
    ptfc_pkg::ptfc_req_s cmd = '0, req;
    ptfc_pkg::ptfc_entry_s entry = '0;
    ptfc_pkg::ptfc_cap_s cap = 16'hF041, cp = 16'hF041;
    ptfc_pkg::ptfc_res_e rsp_result;
    always #2 sys_clk = ~sys_clk;
    ptfc_ep_model u_ep (.*);
    ptfc_checker dut (.*);
    // e: entry, q: kind and flags, p: context privilege select and value
    task automatic run(logic [11:0] e, logic [7:0] q, logic [5:0] r, logic [7:0] f,
                       logic [1:0] p = 2'h0);
        @(posedge sys_clk);
        go <= 1'b1;
        cmd <= q;
        entry <= e;
        cap <= cp;
        {use_ctx_priv, ctx_default_privilege} <= p;
        @(posedge sys_clk);
        go <= 1'b0;
        @(posedge sys_clk);
        #1;
        n_checks++;
        if ({rsp_valid, rsp_result, rsp_reason, rsp_fault} !== {1'b1, r, f, f != 8'h00}) begin
            failures++;
            $display("CHECK FAILED %0t got %h %h", $time, rsp_result, rsp_reason);
        end
    endtask
    task automatic final_report();
        if (failures == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        run(12'h113, 8'h10, 6'h02, 8'h59);
        run(12'h113, 8'h28, 6'h08, 8'h59);
        run(12'h113, 8'h81, 6'h10, 8'h59);
        run(12'h113, 8'h80, 6'h20, 8'h59);
        run(12'h513, 8'h40, 6'h01, 8'h00);
        run(12'h513, 8'h20, 6'h08, 8'h59);
        run(12'hD13, 8'h20, 6'h04, 8'h5A);
        run(12'hD13, 8'h81, 6'h10, 8'h5A);
        run(12'h813, 8'h20, 6'h04, 8'h5B);
        // every type code, each of the four type capabilities cleared in turn, then none cleared
        for (int c = 0; c < 5; c++) begin
            cp[15:12] = 4'hF ^ (4'h8 >> c);
            for (int t = 0; t < 8; t++) begin
                bad = t == 0 || t > 4 || t == c + 1;
                run(12'h903 | 12'(t << 4), 8'h20, bad ? 6'h04 : 6'h01,
                    bad ? 8'h5B : 8'h00);
            end
        end
        run(12'h91F, 8'h20, 6'h04, 8'h5B);
        run(12'h91F, 8'h81, 6'h01, 8'h00);
        run(12'h911, 8'h2C, 6'h08, 8'h5C);
        run(12'h911, 8'h1C, 6'h02, 8'h5C);
        run(12'h911, 8'h24, 6'h01, 8'h00);
        run(12'h910, 8'h2E, 6'h08, 8'h5C);
        run(12'h912, 8'h12, 6'h02, 8'h5D);
        run(12'h912, 8'h22, 6'h08, 8'h5D);
        run(12'h912, 8'h10, 6'h02, 8'h5D, 2'h3);
        run(12'h912, 8'h12, 6'h01, 8'h00, 2'h2);
        final_report();
    end
endmodule // ptfc_checker_tb
